// >>> src/catc_pkg.sv
// Purpose: Shared constants and types for the card area strobe timing block.
// Assumes: Two 16-bit control registers, CTRL and WAIT2, reached over a plain strobe port.
// Notes:   Bit positions of the split delay fields are named individually.
package catc_pkg;

  // Register map; offsets are word indices on the plain register port.
  localparam logic [3:0]  CATC_OFS_CTRL  = 4'h0;
  localparam logic [3:0]  CATC_OFS_WAIT2 = 4'h1;
  localparam logic [3:0]  CATC_OFS_STAT  = 4'h2;
  localparam logic [15:0] CATC_CTRL_RST  = 16'h0000;
  localparam logic [15:0] CATC_WAIT2_RST = 16'h0000;

  // Control register field positions.
  localparam int CATC_AREA6_WAIT_TOP_BIT_POS = 15;
  localparam int CATC_AREA5_WAIT_TOP_BIT_POS = 14;
  localparam int CATC_A5AD_HI  = 11;
  localparam int CATC_A5AD_M   = 7;
  localparam int CATC_A5AD_LO  = 6;
  localparam int CATC_A6AD_HI  = 10;
  localparam int CATC_A6AD_M   = 5;
  localparam int CATC_A6AD_LO  = 4;
  localparam int CATC_A5ND_HI  = 9;
  localparam int CATC_A5ND_M   = 3;
  localparam int CATC_A5ND_LO  = 2;
  localparam int CATC_A6ND_HI  = 8;
  localparam int CATC_A6ND_M   = 1;
  localparam int CATC_A6ND_LO  = 0;
  localparam logic [15:0] CATC_CTRL_MASK = 16'hCFFF;

  // Second wait control: three low wait bits per area.
  localparam int CATC_A5WL_LSB = 0;
  localparam int CATC_A6WL_LSB = 4;
  localparam logic [15:0] CATC_WAIT2_MASK = 16'h0077;

  // Access request from the area decoder.
  typedef struct packed {
    logic area6;
    logic write;
    logic burst;
  } catc_req_type;

  // Timing set derived for one access.
  typedef struct packed {
    logic [2:0] assert_dly;
    logic [2:0] negate_dly;
    logic [5:0] waits;
    logic       wait_pin_en;
  } catc_timing_type;

  typedef enum logic [2:0] {
    CATC_IDLE   = 3'b000,
    CATC_SETUP  = 3'b001,
    CATC_STROBE = 3'b010,
    CATC_WAITP  = 3'b011,
    CATC_HOLD   = 3'b100
  } catc_state_type;

endpackage

// >>> src/catc_strobe_timing.sv
// Purpose: Strobe timing sequencer for the card interface in areas 5 and 6.
// Assumes: Delays count in whole cycles; the counter steps once per rising CORE_CLK edge.
// Notes:   Times below are in whole cycles of CORE_CLK; strobes are active low.
//
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module catc_strobe_timing
  import catc_pkg::*;
(
  input  wire logic         CORE_CLK,
  input  wire logic         SRST,
  input  wire logic [3:0]   ADDR,
  input  wire logic [15:0]  WDATA,
  input  wire logic         WR,
  input  wire logic         RD,
  output logic      [15:0]  RDATA,
  input  wire catc_req_type REQ,
  input  wire logic         REQ_VALID,
  output logic              REQ_READY,
  input  wire logic         WAIT_PIN_N,
  output logic              ADDR_VALID,
  output logic              OE_N,
  output logic              WE_N,
  output logic              DONE
);

  // Register file and sequencer state.
  logic [15:0]     ctrl_ff;
  logic [15:0]     wait2_ff;
  logic [15:0]     rdata_ff;
  catc_state_type  state_ff;
  catc_state_type  nxt_state;
  logic [6:0]      cnt_ff;
  logic [6:0]      nxt_cnt;
  catc_req_type    req_ff;
  catc_timing_type tim_ff;
  logic            wsync1_ff;
  logic            wsync2_ff;
  logic            oe_n_ff;
  logic            we_n_ff;
  logic            addr_ff;
  logic            done_ff;

  // Maps a four-bit wait code to first-cycle waits.
  function automatic logic [5:0] wait_count(input logic [3:0] code);
    logic [5:0] w;
    w = 6'h00;
    case (code)
      4'h0: w = 6'h00;
      4'h1: w = 6'h01;
      4'h2: w = 6'h02;
      4'h3: w = 6'h03;
      4'h4: w = 6'h04;
      4'h5: w = 6'h06;
      4'h6: w = 6'h08;
      4'h7: w = 6'h0A;
      4'h8: w = 6'h0C;
      4'h9: w = 6'h0E;
      4'hA: w = 6'h12;
      4'hB: w = 6'h16;
      4'hC: w = 6'h1A;
      4'hD: w = 6'h1E;
      4'hE: w = 6'h22;
      default: w = 6'h26;
    endcase
    return w;
  endfunction

  // Burst states per transfer: two for codes 0 and 1, else waits plus one.
  function automatic logic [5:0] burst_states(input logic [3:0] code);
    logic [5:0] b;
    b = wait_count(code) + 6'h01;
    if (code < 4'h2) begin
      b = 6'h02;
    end
    return b;
  endfunction

  // Field extraction from the split control bit positions.
  wire logic [2:0] a5_assert_delay = {ctrl_ff[CATC_A5AD_HI], ctrl_ff[CATC_A5AD_M],
                                      ctrl_ff[CATC_A5AD_LO]};
  wire logic [2:0] area6_assert_delay = {ctrl_ff[CATC_A6AD_HI], ctrl_ff[CATC_A6AD_M],
                                         ctrl_ff[CATC_A6AD_LO]};
  wire logic [2:0] area5_negate_delay = {ctrl_ff[CATC_A5ND_HI], ctrl_ff[CATC_A5ND_M],
                                         ctrl_ff[CATC_A5ND_LO]};
  wire logic [2:0] area6_negate_delay = {ctrl_ff[CATC_A6ND_HI], ctrl_ff[CATC_A6ND_M],
                                         ctrl_ff[CATC_A6ND_LO]};
  wire logic [3:0] a5_code = {ctrl_ff[CATC_AREA5_WAIT_TOP_BIT_POS],
                              wait2_ff[CATC_A5WL_LSB +: 3]};
  wire logic [3:0] a6_code = {ctrl_ff[CATC_AREA6_WAIT_TOP_BIT_POS],
                              wait2_ff[CATC_A6WL_LSB +: 3]};
  wire logic [3:0] sel_code = REQ.area6 ? a6_code : a5_code;

  // Timing chosen for the incoming access.
  catc_timing_type req_tim;
  assign req_tim.assert_dly  = REQ.area6 ? area6_assert_delay : a5_assert_delay;
  assign req_tim.negate_dly  = REQ.area6 ? area6_negate_delay : area5_negate_delay;
  assign req_tim.waits       = REQ.burst ? (burst_states(sel_code) - 6'h01)
                                         : wait_count(sel_code);
  assign req_tim.wait_pin_en = REQ.burst || (sel_code != 4'h0);

  // Register decode and read mux.
  wire logic sel_ctrl  = (ADDR == CATC_OFS_CTRL);
  wire logic sel_wait2 = (ADDR == CATC_OFS_WAIT2);
  wire logic sel_stat  = (ADDR == CATC_OFS_STAT);
  wire logic [15:0] stat_word = {13'h0000, state_ff};
  wire logic [15:0] rd_mux = sel_ctrl  ? ctrl_ff :
                             sel_wait2 ? wait2_ff :
                             sel_stat  ? stat_word : 16'h0000;

  // Register writes; reserved bits stay zero.
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      ctrl_ff  <= CATC_CTRL_RST;
      wait2_ff <= CATC_WAIT2_RST;
      rdata_ff <= 16'h0000;
    end else begin
      if (WR && sel_ctrl) begin
        ctrl_ff <= WDATA & CATC_CTRL_MASK;
      end
      if (WR && sel_wait2) begin
        wait2_ff <= WDATA & CATC_WAIT2_MASK;
      end
      rdata_ff <= RD ? rd_mux : 16'h0000;
    end
  end

  // Two-flop synchroniser for the external wait input.
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      wsync1_ff <= 1'b1;
      wsync2_ff <= 1'b1;
    end else begin
      wsync1_ff <= WAIT_PIN_N;
      wsync2_ff <= wsync1_ff;
    end
  end

  wire logic wait_hold = tim_ff.wait_pin_en && !wsync2_ff;
  wire logic cnt_zero  = (cnt_ff == 7'h00);
  assign REQ_READY = (state_ff == CATC_IDLE);

  // Sequencer: counts are in whole cycles, one per clock.
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    case (state_ff)
      CATC_IDLE: begin
        if (REQ_VALID) begin
          nxt_state = CATC_SETUP;
          nxt_cnt   = {4'h0, req_tim.assert_dly};
        end
      end
      CATC_SETUP: begin
        if (cnt_zero) begin
          nxt_state = CATC_STROBE;
          nxt_cnt   = {1'b0, tim_ff.waits};
        end else begin
          nxt_cnt = cnt_ff - 7'h01;
        end
      end
      CATC_STROBE: begin
        if (!cnt_zero) begin
          nxt_cnt = cnt_ff - 7'h01;
        end else if (!wait_hold) begin
          nxt_state = CATC_HOLD;
          nxt_cnt   = {4'h0, tim_ff.negate_dly};
        end else begin
          nxt_state = CATC_WAITP;
        end
      end
      CATC_WAITP: begin
        if (!wait_hold) begin
          nxt_state = CATC_HOLD;
          nxt_cnt   = {4'h0, tim_ff.negate_dly};
        end
      end
      CATC_HOLD: begin
        if (cnt_zero) begin
          nxt_state = CATC_IDLE;
        end else begin
          nxt_cnt = cnt_ff - 7'h01;
        end
      end
      default: nxt_state = CATC_IDLE;
    endcase
  end

  // State, captured request and registered pin outputs.
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      state_ff <= CATC_IDLE;
      cnt_ff   <= 7'h00;
      req_ff   <= '0;
      tim_ff   <= '0;
      oe_n_ff  <= 1'b1;
      we_n_ff  <= 1'b1;
      addr_ff  <= 1'b0;
      done_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      if (REQ_VALID && REQ_READY) begin
        req_ff <= REQ;
        tim_ff <= req_tim;
      end
      oe_n_ff <= !((nxt_state == CATC_STROBE || nxt_state == CATC_WAITP) && !req_ff.write);
      we_n_ff <= !((nxt_state == CATC_STROBE || nxt_state == CATC_WAITP) && req_ff.write);
      addr_ff <= (nxt_state != CATC_IDLE);
      done_ff <= (state_ff == CATC_HOLD) && cnt_zero;
    end
  end

  assign RDATA      = rdata_ff;
  assign ADDR_VALID = addr_ff;
  assign OE_N       = oe_n_ff;
  assign WE_N       = we_n_ff;
  assign DONE       = done_ff;

  // Setup lasts assert delay plus one clock after acceptance.
  sequence catc_accept_s;
    REQ_VALID && REQ_READY && !REQ.area6;
  endsequence

  setup_len_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    catc_accept_s and (a5_assert_delay == 3'h0) |=> (state_ff == CATC_SETUP) ##1
    (state_ff == CATC_STROBE)) else $error("Setup length wrong.");
  reset_zero_a: assert property (@(posedge CORE_CLK)
    $past(SRST) |-> ctrl_ff == 16'h0000) else $error("Control not reset.");
  a6_field_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    WR && sel_ctrl && !RD |=> area6_assert_delay == {$past(WDATA[10]), $past(WDATA[5]),
    $past(WDATA[4])}) else $error("Area 6 assert field misplaced.");
  a5n_field_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    WR && sel_ctrl |=> area5_negate_delay == {$past(WDATA[9]), $past(WDATA[3]),
    $past(WDATA[2])}) else $error("Area 5 negate field misplaced.");
  a6n_field_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    WR && sel_ctrl |=> area6_negate_delay == {$past(WDATA[8]), $past(WDATA[1]),
    $past(WDATA[0])}) else $error("Area 6 negate field misplaced.");
  hold_end_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    state_ff == CATC_HOLD && cnt_zero |=> state_ff == CATC_IDLE ##0 DONE)
    else $error("Hold did not end.");
  a5_ad_field_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    WR && sel_ctrl |=> a5_assert_delay == {$past(WDATA[11]), $past(WDATA[7]),
    $past(WDATA[6])}) else $error("Area 5 assert field misplaced.");
  zero_wait_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    REQ_VALID && REQ_READY && !REQ.burst && sel_code == 4'h0 |-> !req_tim.wait_pin_en
    && req_tim.waits == 6'h00) else $error("Zero wait code mishandled.");
  top_bit_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    a5_code == 4'hF |-> wait_count(a5_code) == 6'h26) else $error("Area 5 code map.");
  strobe_width_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
    state_ff == CATC_SETUP && cnt_zero |=> cnt_ff == {1'b0, tim_ff.waits})
    else $error("Strobe width not from wait code.");

endmodule // catc_strobe_timing

// >>> test/catc_card_model.sv
// Purpose: Behavioural card that stretches accesses with its wait line.
// Assumes: The wait line is active low with a pull-up, so it idles high.
// Notes:   HOLD_CYC cycles of wait follow each falling strobe.
`timescale 1ns/1ps
module catc_card_model (
  input  wire logic       CORE_CLK,
  input  wire logic       OE_N,
  input  wire logic       WE_N,
  input  wire logic [5:0] HOLD_CYC,
  output logic            WAIT_PIN_N
);
  logic       strobe_d_ff = 1'b1;
  logic [5:0] cnt_ff      = 6'h00;
  // Loads the wait length when a strobe falls, then counts it down.
  always_ff @(posedge CORE_CLK) begin
    strobe_d_ff <= OE_N & WE_N;
    if (strobe_d_ff && !(OE_N & WE_N)) begin
      cnt_ff <= HOLD_CYC;
    end else if (cnt_ff != 6'h00) begin
      cnt_ff <= cnt_ff - 6'h01;
    end
  end
  // A released line returns to its pull-up level.
  assign WAIT_PIN_N = (cnt_ff == 6'h00);
endmodule // catc_card_model

// >>> test/tb_top.sv
// Purpose: Self-checking bench for the card area strobe timing block.
// Assumes: Delay code n gives n+1 setup or hold cycles, as handed over.
// Notes:   Ordinary accesses come from a table; wait line cases follow it.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module tb_top;
  import catc_pkg::*;
  typedef struct {logic a6; logic wr; logic bu; logic [3:0] wc; logic [2:0] ad; logic [2:0] nd;}
    catc_row_type;
  localparam int WTAB[16] = '{0, 1, 2, 3, 4, 6, 8, 10, 12, 14, 18, 22, 26, 30, 34, 38};
  logic core_clk, srst, wr, rd, req_valid, req_ready, wait_pin_n;
  logic addr_valid, oe_n, we_n, done;
  logic [3:0]   addr;
  logic [15:0]  wdata, rdata;
  logic [5:0]   hold_cyc;
  catc_req_type req;
  int n_mismatch, tests_run, su, st, ho, bad;
  catc_row_type rows[6] = '{'{1, 0, 0, 0, 0, 0}, '{1, 1, 0, 15, 7, 7}, '{0, 0, 0, 9, 5, 2},
                            '{0, 1, 1, 1, 3, 1}, '{1, 0, 1, 10, 2, 6}, '{0, 0, 1, 0, 6, 4}};
  catc_strobe_timing catc_strobe_timing_inst (.CORE_CLK(core_clk), .SRST(srst), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .REQ(req), .REQ_VALID(req_valid),
    .REQ_READY(req_ready), .WAIT_PIN_N(wait_pin_n), .ADDR_VALID(addr_valid), .OE_N(oe_n),
    .WE_N(we_n), .DONE(done));
  catc_card_model catc_card_model_inst (.CORE_CLK(core_clk), .OE_N(oe_n), .WE_N(we_n),
    .HOLD_CYC(hold_cyc), .WAIT_PIN_N(wait_pin_n));
  // Free-running 25 MHz clock.
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // One-cycle register write.
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask
  // One-cycle register read; data is looked at in the cycle after the strobe.
  task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk);
    addr <= a; rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Places the split delay fields at their register bits.
  function automatic logic [15:0] ctrl_of(logic a5w, logic a6w, logic [2:0] a5a, logic [2:0] a6a,
                                          logic [2:0] a5n, logic [2:0] a6n);
    return {a6w, a5w, 2'b00, a5a[2], a6a[2], a5n[2], a6n[2], a5a[1:0], a6a[1:0], a5n[1:0], a6n[1:0]};
  endfunction
  // Issues one access and measures setup, strobe and hold lengths in cycles.
  task automatic access(input catc_req_type r);
    int i;
    su = 0; st = 0; ho = 0; bad = 0;
    @(posedge core_clk);
    req <= r; req_valid <= 1'b1;
    #1;
    for (i = 0; i < 300 && done !== 1'b1; i++) begin
      @(posedge core_clk);
      req_valid <= 1'b0;
      #1;
      if (oe_n === 1'b0 || we_n === 1'b0) begin
        st++;
        if ((r.write ? oe_n : we_n) !== 1'b1) bad++;
      end else if (addr_valid === 1'b1) begin
        if (st == 0) su++; else ho++;
      end
    end
    if (i == 300) begin
      n_mismatch++;
      end_sim();
    end
  endtask
  logic [15:0] d, c;
  int exp_st;
  initial begin
    srst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 4'h0; wdata = 16'h0000;
    req = '0; req_valid = 1'b0; hold_cyc = 6'h00; n_mismatch = 0; tests_run = 0;
    repeat (10) @(posedge core_clk);
    srst <= 1'b0;
    #1 `CHK("idle_strobes", 3'b111, {oe_n, we_n, req_ready})
    reg_rd(CATC_OFS_CTRL, d);  `CHK("ctrl_reset", 16'h0000, d)
    reg_rd(CATC_OFS_WAIT2, d); `CHK("wait2_reset", 16'h0000, d)
    reg_wr(CATC_OFS_CTRL, 16'hFFFF);
    reg_rd(CATC_OFS_CTRL, d);  `CHK("ctrl_mask", 16'hCFFF, d)
    reg_rd(4'h3, d);           `CHK("unmapped", 16'h0000, d)
    // Table of ordinary accesses; the other area gets different codes.
    foreach (rows[k]) begin
      c = rows[k].a6 ? ctrl_of(~rows[k].wc[3], rows[k].wc[3], ~rows[k].ad, rows[k].ad,
                               ~rows[k].nd, rows[k].nd)
                     : ctrl_of(rows[k].wc[3], ~rows[k].wc[3], rows[k].ad, ~rows[k].ad,
                               rows[k].nd, ~rows[k].nd);
      reg_wr(CATC_OFS_CTRL, c);
      reg_rd(CATC_OFS_CTRL, d); `CHK("ctrl_fields", c, d)
      d = rows[k].a6 ? {9'h000, rows[k].wc[2:0], 1'b0, ~rows[k].wc[2:0]}
                     : {9'h000, ~rows[k].wc[2:0], 1'b0, rows[k].wc[2:0]};
      reg_wr(CATC_OFS_WAIT2, d);
      access('{area6: rows[k].a6, write: rows[k].wr, burst: rows[k].bu});
      exp_st = (rows[k].bu && rows[k].wc < 2) ? 2 : WTAB[rows[k].wc] + 1;
      `CHK("setup_len", rows[k].ad + 1, su)
      `CHK("strobe_len", exp_st, st)
      `CHK("hold_len", rows[k].nd + 1, ho)
      `CHK("strobe_kind", 0, bad)
    end
    // Wait line is ignored at code zero but stretches the strobe at code four.
    hold_cyc <= 6'h06;
    reg_wr(CATC_OFS_CTRL, 16'h0000);
    reg_wr(CATC_OFS_WAIT2, 16'h0000);
    access('{area6: 1'b1, write: 1'b0, burst: 1'b0});
    `CHK("wait_ignored_first", 1, st)
    // The card still holds its wait line low here, so this access must ignore it.
    access('{area6: 1'b1, write: 1'b0, burst: 1'b0});
    `CHK("wait_ignored", 1, st)
    reg_wr(CATC_OFS_WAIT2, 16'h0040);
    access('{area6: 1'b1, write: 1'b1, burst: 1'b0});
    `CHK("wait_stretch", 1'b1, st > 5)
    end_sim();
  end
endmodule // tb_top
